/* File: core/bec_pkg.sv */
// Constants and carrier types for the bus-enable and clock-run control.
// Assumes an 8-bit register port and pins synchronised before use.
package bec_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] BEC_OFS_BUS_CFG = 8'h1B;
  localparam logic [7:0] BEC_OFS_TMR_CFG = 8'h0A;
  localparam logic [7:0] BEC_OFS_STATUS = 8'h3E;

  // Bus configuration field positions
  localparam int BEC_BUS_EXT_BIT = 0;
  localparam int BEC_BUS_EDGE_A_BIT = 1;
  localparam int BEC_BUS_TRACE_BIT = 3;
  localparam int BEC_BUS_EDGE_B_BIT = 4;
  localparam int BEC_BUS_EDGE_C_BIT = 5;
  localparam int BEC_BUS_IRQ_SEL_BIT = 6;
  localparam int BEC_BUS_EMU_BIT = 7;

  // Timer configuration one field positions
  localparam int BEC_TMR_CLK_SEL_BIT = 1;
  localparam int BEC_TMR_FOSC_EN_BIT = 2;

  // Reset values
  localparam logic [7:0] BEC_BUS_CFG_RST = 8'h00;
  localparam logic [7:0] BEC_BUS_CFG_EMU = 8'h89;
  localparam logic [7:0] BEC_TMR_CFG_RST = 8'h00;
  localparam logic [7:0] BEC_PORT3_RST = 8'hFF;
  localparam logic [2:0] BEC_IRQ_N_RST = 3'h7;

  // Pins that cross into the system clock domain
  typedef struct packed {
    logic [2:0] irq_n;
    logic [7:0] data;
    logic [15:0] addr;
    logic we_n;
    logic fast;
    logic slow;
    logic rst_n;
    logic bus_en;
  } bec_pin_s;

  localparam int BEC_PIN_W = $bits(bec_pin_s);

  // Whole state of the control block
  typedef struct packed {
    logic phase;
    logic rst_prev;
    logic bus_en_prev;
    logic [7:0] bus_cfg;
    logic [7:0] tmr_cfg;
    logic halted;
    logic stopped;
    logic pend_wait;
    logic pend_stop;
    logic dma;
    logic [7:0] rdata;
    logic run_pin;
    logic slow_ob;
    logic fast_ob;
    logic cpu_ready;
    logic cpu_reset;
    logic [15:0] addr_o;
    logic [15:0] addr_oe;
    logic [7:0] data_o;
    logic [7:0] data_oe;
    logic we_n_o;
    logic we_n_oe;
    logic dma_wr;
    logic dma_rd;
    logic [15:0] dma_addr;
    logic [7:0] dma_wdata;
    logic [7:0] p3_o;
    logic [2:0] irq_n;
    logic [2:0] edge_sel;
  } bec_state_s;

endpackage

/* File: core/bec_pin_sync.sv */
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
module bec_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  // First stage feeds only the second
  always_comb begin
    st_d[0] = d_i;
    st_d[1] = st_q[0];
    if (!resetn_i) begin
      st_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_q <= st_d;
  end

  assign q_o = st_q[1];

endmodule

/* File: core/bec_ctrl.sv */
// Bus-enable direction, clock-run and clock-source control.
// Assumes the core, memories and port registers on sys_clk_i.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module bec_ctrl (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Pin inputs
  input wire logic bus_enable_in_i,
  input wire logic reset_n_pin_i,
  input wire logic slow_clock_in_i,
  input wire logic fast_clock_in_i,
  input wire logic write_enable_n_i,
  input wire logic [15:0] addr_pin_i,
  input wire logic [7:0] data_pin_i,
  input wire logic [2:0] irq_pin_n_i,
  // Pin outputs
  output logic write_enable_n_o,
  output logic write_enable_n_oe_o,
  output logic [15:0] addr_pin_o,
  output logic [15:0] addr_pin_oe_o,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe_o,
  output logic clock_request_out_o,
  output logic system_phase_clock_o,
  output logic slow_clock_osc_out_o,
  output logic fast_clock_osc_out_o,
  output logic fast_osc_en_o,
  output logic [7:0] port3_pin_o,
  // Core side
  input wire logic wait_for_interrupt_instr_i,
  input wire logic stop_instr_i,
  input wire logic opcode_fetch_flag_i,
  input wire logic irq_wake_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_we_i,
  input wire logic cpu_ext_i,
  input wire logic [7:0] int_bus_data_i,
  input wire logic [7:0] mem_rdata_i,
  output logic cpu_ready_o,
  output logic cpu_reset_o,
  // DMA into internal memory
  output logic dma_wr_o,
  output logic dma_rd_o,
  output logic [15:0] dma_addr_o,
  output logic [7:0] dma_wdata_o,
  // Port functions
  input wire logic [23:0] port_out_i,
  input wire logic [23:0] port_dir_i,
  input wire logic [7:0] port3_data_i,
  input wire logic [7:0] chip_select_n_i,
  input wire logic [7:0] chip_select_enable_i,
  output logic nonmaskable_irq_n_o,
  output logic level_irq_one_n_o,
  output logic level_irq_two_n_o,
  output logic [2:0] edge_irq_sel_o
);

  bec_pkg::bec_pin_s pin_s;
  bec_pkg::bec_state_s st_q;
  bec_pkg::bec_state_s nxt;
  logic rst_rise;
  logic sel_clk;
  logic ext_wr;
  logic trace;
  logic bus_sel;
  logic wake;
  logic ph_rise;
  logic ph_fall;
  logic [7:0] cs_sel;

  bec_pin_sync #(
    .W(bec_pkg::BEC_PIN_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i({irq_pin_n_i, data_pin_i, addr_pin_i, write_enable_n_i,
          fast_clock_in_i, slow_clock_in_i, reset_n_pin_i,
          bus_enable_in_i}),
    .q_o(pin_s)
  );

  assign rst_rise = pin_s.rst_n & ~st_q.rst_prev;
  assign trace = st_q.bus_cfg[bec_pkg::BEC_BUS_TRACE_BIT];
  assign bus_sel = st_q.bus_cfg[bec_pkg::BEC_BUS_EXT_BIT] | trace |
                   st_q.bus_cfg[bec_pkg::BEC_BUS_EMU_BIT];
  assign ext_wr = cpu_we_i & cpu_ext_i;
  assign wake = irq_wake_i | rst_rise;
  // Clock source select
  // Fast input counts only while its oscillator is enabled
  assign sel_clk = st_q.tmr_cfg[bec_pkg::BEC_TMR_CLK_SEL_BIT] ?
                   (pin_s.fast & st_q.tmr_cfg[bec_pkg::BEC_TMR_FOSC_EN_BIT]) :
                   pin_s.slow;
  assign cs_sel = chip_select_enable_i |
                  {st_q.bus_cfg[bec_pkg::BEC_BUS_EMU_BIT], 7'h00};

  always_comb begin
    nxt = st_q;
    nxt.rst_prev = pin_s.rst_n;
    nxt.bus_en_prev = pin_s.bus_en;
    nxt.dma_wr = 1'b0;
    nxt.dma_rd = 1'b0;
    nxt.rdata = 8'h00;
    nxt.cpu_reset = ~pin_s.rst_n;
    nxt.slow_ob = ~pin_s.slow;
    nxt.fast_ob = ~pin_s.fast;

    // Register writes
    if (reg_we_i && reg_addr_i == bec_pkg::BEC_OFS_BUS_CFG) begin
      nxt.bus_cfg = reg_wdata_i;
    end
    if (reg_we_i && reg_addr_i == bec_pkg::BEC_OFS_TMR_CFG) begin
      nxt.tmr_cfg = reg_wdata_i;
    end
    if (!pin_s.rst_n) begin
      nxt.tmr_cfg = bec_pkg::BEC_TMR_CFG_RST;
    end
    if (rst_rise) begin
      nxt.bus_cfg = pin_s.bus_en ? bec_pkg::BEC_BUS_CFG_RST :
                                   bec_pkg::BEC_BUS_CFG_EMU;
    end

    // Register reads, data valid the next cycle only
    if (reg_re_i) begin
      case (reg_addr_i)
        bec_pkg::BEC_OFS_BUS_CFG: nxt.rdata = st_q.bus_cfg;
        bec_pkg::BEC_OFS_TMR_CFG: nxt.rdata = st_q.tmr_cfg;
        bec_pkg::BEC_OFS_STATUS: nxt.rdata = {4'h0, st_q.dma, st_q.stopped,
                                               st_q.halted, st_q.phase};
        default: nxt.rdata = 8'h00;
      endcase
    end

    // Wait request held until high phase
    if (wait_for_interrupt_instr_i) begin
      nxt.pend_wait = 1'b1;
    end
    if (stop_instr_i) begin
      nxt.pend_stop = 1'b1;
    end
    if (st_q.phase && (nxt.pend_wait || nxt.pend_stop)) begin
      nxt.halted = 1'b1;
      nxt.stopped = nxt.pend_stop;
      nxt.pend_wait = 1'b0;
      nxt.pend_stop = 1'b0;
    end
    // Wake restarts the clock
    // Wake beats a same-cycle entry: the interrupt is already there
    if (wake || !pin_s.rst_n) begin
      nxt.halted = 1'b0;
      nxt.stopped = 1'b0;
      nxt.pend_wait = 1'b0;
      nxt.pend_stop = 1'b0;
    end

    nxt.phase = nxt.stopped ? 1'b1 : sel_clk;
    ph_rise = nxt.phase & ~st_q.phase;
    ph_fall = st_q.phase & ~nxt.phase;

    // Fetch flag in low phase under trace
    // Run pin built without bus enable
    if (nxt.bus_cfg[bec_pkg::BEC_BUS_TRACE_BIT] && !nxt.phase) begin
      nxt.run_pin = opcode_fetch_flag_i;
    end else begin
      nxt.run_pin = ~nxt.halted;
    end

    // Bus enable falling in low phase
    if (st_q.bus_en_prev && !pin_s.bus_en && !st_q.phase) begin
      nxt.dma = 1'b1;
    end
    if (pin_s.bus_en) begin
      nxt.dma = 1'b0;
    end
    // Halted core or low bus enable stalls
    nxt.cpu_ready = pin_s.bus_en & ~nxt.halted & pin_s.rst_n;

    if (nxt.dma) begin
      nxt.dma_addr = pin_s.addr;
      nxt.dma_wdata = pin_s.data;
      nxt.dma_wr = ph_fall & ~pin_s.we_n;
      nxt.dma_rd = ph_rise & pin_s.we_n;
    end

    // Address and data pins
    nxt.data_o = cpu_wdata_i;
    nxt.data_oe = 8'h00;
    if (nxt.dma) begin
      nxt.addr_o = 16'h0000;
      nxt.addr_oe = 16'h0000;
      if (pin_s.we_n && nxt.phase) begin
        nxt.data_o = mem_rdata_i;
        nxt.data_oe = 8'hFF;
      end
    end else if (bus_sel) begin
      // Core owns the bus
      // Internal cycles show all ones unless traced
      nxt.addr_o = (cpu_ext_i || trace) ? cpu_addr_i : 16'hFFFF;
      nxt.addr_oe = 16'hFFFF;
      if (ext_wr && nxt.phase) begin
        nxt.data_oe = 8'hFF;
      end else if (trace && !cpu_ext_i && nxt.phase) begin
        nxt.data_o = int_bus_data_i;
        nxt.data_oe = 8'hFF;
      end
    end else begin
      // Port function when bus not selected
      nxt.addr_o = port_out_i[15:0];
      nxt.addr_oe = port_dir_i[15:0];
      nxt.data_o = port_out_i[23:16];
      nxt.data_oe = port_dir_i[23:16];
    end

    // Strobe low only for external writes
    nxt.we_n_o = ~ext_wr;
    // Strobe becomes an input during DMA
    nxt.we_n_oe = ~nxt.dma;

    for (int i = 0; i < 8; i++) begin
      nxt.p3_o[i] = cs_sel[i] ? chip_select_n_i[i] : port3_data_i[i];
    end
    nxt.irq_n = nxt.bus_cfg[bec_pkg::BEC_BUS_IRQ_SEL_BIT] ? pin_s.irq_n :
                bec_pkg::BEC_IRQ_N_RST;
    nxt.edge_sel = {nxt.bus_cfg[bec_pkg::BEC_BUS_EDGE_C_BIT],
                    nxt.bus_cfg[bec_pkg::BEC_BUS_EDGE_B_BIT],
                    nxt.bus_cfg[bec_pkg::BEC_BUS_EDGE_A_BIT]};

    if (!resetn_i) begin
      nxt = '0;
      nxt.bus_cfg = bec_pkg::BEC_BUS_CFG_RST;
      nxt.tmr_cfg = bec_pkg::BEC_TMR_CFG_RST;
      nxt.run_pin = 1'b1;
      nxt.cpu_reset = 1'b1;
      nxt.we_n_o = 1'b1;
      nxt.p3_o = bec_pkg::BEC_PORT3_RST;
      nxt.irq_n = bec_pkg::BEC_IRQ_N_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_q <= nxt;
  end

  assign reg_rdata_o = st_q.rdata;
  assign write_enable_n_o = st_q.we_n_o;
  assign write_enable_n_oe_o = st_q.we_n_oe;
  assign addr_pin_o = st_q.addr_o;
  assign addr_pin_oe_o = st_q.addr_oe;
  assign data_pin_o = st_q.data_o;
  assign data_pin_oe_o = st_q.data_oe;
  assign clock_request_out_o = st_q.run_pin;
  assign system_phase_clock_o = st_q.phase;
  assign slow_clock_osc_out_o = st_q.slow_ob;
  assign fast_clock_osc_out_o = st_q.fast_ob;
  assign fast_osc_en_o = st_q.tmr_cfg[bec_pkg::BEC_TMR_FOSC_EN_BIT];
  assign port3_pin_o = st_q.p3_o;
  assign cpu_ready_o = st_q.cpu_ready;
  assign cpu_reset_o = st_q.cpu_reset;
  assign dma_wr_o = st_q.dma_wr;
  assign dma_rd_o = st_q.dma_rd;
  assign dma_addr_o = st_q.dma_addr;
  assign dma_wdata_o = st_q.dma_wdata;
  assign nonmaskable_irq_n_o = st_q.irq_n[0];
  assign level_irq_one_n_o = st_q.irq_n[1];
  assign level_irq_two_n_o = st_q.irq_n[2];
  assign edge_irq_sel_o = st_q.edge_sel;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_WE_EXT_ONLY: assert property (
    $past(resetn_i) && !write_enable_n_o |-> $past(ext_wr))
    else $error("strobe low without external write");
  AST_WE_INPUT_DMA: assert property (
    st_q.dma |-> !write_enable_n_oe_o && addr_pin_oe_o == 16'h0000)
    else $error("strobe or address driven during DMA");
  AST_HALT_STALLS: assert property (
    st_q.halted |-> !cpu_ready_o)
    else $error("core ready while halted");
  AST_TRACE_FETCH: assert property (
    $past(resetn_i) && trace && !system_phase_clock_o
    |-> clock_request_out_o == $past(opcode_fetch_flag_i))
    else $error("fetch flag not on run pin");
  AST_HALT_HIGH_PHASE: assert property (
    $rose(st_q.halted) |-> $past(st_q.phase))
    else $error("halt entered in low phase");
  AST_STOP_FREEZE: assert property (
    st_q.stopped && $past(st_q.stopped) |-> system_phase_clock_o
    && $stable(system_phase_clock_o))
    else $error("phase clock moved while stopped");
  AST_WAKE_RUN: assert property (
    $past(irq_wake_i) && $past(st_q.halted) |-> !st_q.halted
    && !st_q.stopped ##1 1'b1)
    else $error("wake did not restart");
  AST_FOSC_RESET: assert property (
    $past(resetn_i) && $past(!pin_s.rst_n) |-> !fast_osc_en_o)
    else $error("oscillator enabled during reset");
  AST_CLK_SELECT: assert property (
    $past(resetn_i) && !st_q.stopped
    |-> system_phase_clock_o == $past(sel_clk))
    else $error("phase clock from wrong source");
  AST_OSC_INVERT: assert property (
    $past(resetn_i) |-> slow_clock_osc_out_o == !$past(pin_s.slow)
    && fast_clock_osc_out_o == !$past(pin_s.fast))
    else $error("oscillator output not inverted");
  AST_EMU_BOOT: assert property (
    $past(rst_rise) && !$past(pin_s.bus_en)
    |-> st_q.bus_cfg == bec_pkg::BEC_BUS_CFG_EMU)
    else $error("emulation mode not selected");
  AST_READY_STALL: assert property (
    $past(resetn_i) && $past(!pin_s.bus_en) |-> !cpu_ready_o)
    else $error("core ready with bus enable low");
  AST_DMA_READ_DATA: assert property (
    st_q.dma && data_pin_oe_o != 8'h00 |-> data_pin_o == $past(mem_rdata_i))
    else $error("DMA read data wrong");

  COV_DMA: cover property ($rose(st_q.dma));
  COV_STOP: cover property ($rose(st_q.stopped) ##[1:50] !st_q.stopped);
  COV_EMU: cover property ($past(rst_rise) && !$past(pin_s.bus_en));
  COV_DMA_WR: cover property (dma_wr_o);

endmodule

/* File: sim/bec_far_end.sv */
// Far-side model: oscillators and emulator bus-enable gating.
// Assumes the device phase clock level is fed back in.
`timescale 1ns/1ps
module bec_far_end #(
  parameter int SLOW_HALF = 24,
  parameter int FAST_HALF = 6
) (
  // Clock
  input wire logic sys_clk_i,
  // Emulator controls
  input wire logic keep_bus_i,
  input wire logic ready_i,
  input wire logic phase_i,
  // Pins to the device
  output logic bus_enable_o,
  output logic slow_clk_o,
  output logic fast_clk_o
);
  int cnt = 0;
  initial begin
    slow_clk_o = 1'b0;
    fast_clk_o = 1'b0;
  end
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 1;
    if (cnt % FAST_HALF == FAST_HALF - 1) fast_clk_o <= ~fast_clk_o;
    if (cnt % SLOW_HALF == SLOW_HALF - 1) slow_clk_o <= ~slow_clk_o;
  end
  assign bus_enable_o = keep_bus_i & (ready_i | ~phase_i);
endmodule

/* File: sim/bec_ctrl_tb.sv */
// Self-checking bench for the bus-enable and clock-run control.
// Assumes the far-side model makes oscillators and bus enable.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end \
  end
module bec_ctrl_tb;
  logic clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, keep = 1'b1;
  logic rdy = 1'b1, rpin = 1'b0, wpin = 1'b1, wait_for_interrupt_instr = 1'b0, stop_instr = 1'b0;
  logic fet = 1'b0, wake = 1'b0, cwe = 1'b0, cext = 1'b0;
  logic [7:0] ra = 8'h00, wdat = 8'h00, idat = 8'h00, mdat = 8'h3C;
  logic [7:0] dpin = 8'h00, p3d = 8'h55, csn = 8'hAA, csen = 8'h0F;
  logic [15:0] apin = 16'h0000;
  logic [23:0] pout = 24'h00A5C3, pdir = 24'h3CF00F;
  logic [2:0] irqn = 3'h2;
  logic be, slow, fast, weo, weoe, run, ph, sob, fob, fosc, crdy;
  logic dwr, drd, nmi, crst, l1, l2;
  logic [15:0] cadr = 16'h4321;
  logic [7:0] cwd = 8'h96;
  logic [7:0] rdat, dout, doe, p3, dwd, cap_d, v;
  logic [15:0] ao, aoe, dadr, cap_a;
  logic [2:0] esel;
  int fail_count = 0, checks = 0, cycles = 0, nwr = 0, nrd = 0, n;

  bec_ctrl i_dut (
    .sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(ra),
    .reg_wdata_i(wdat), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdat), .bus_enable_in_i(be), .reset_n_pin_i(rpin),
    .slow_clock_in_i(slow), .fast_clock_in_i(fast),
    .write_enable_n_i(wpin), .addr_pin_i(apin), .data_pin_i(dpin),
    .irq_pin_n_i(irqn), .write_enable_n_o(weo),
    .write_enable_n_oe_o(weoe), .addr_pin_o(ao), .addr_pin_oe_o(aoe),
    .data_pin_o(dout), .data_pin_oe_o(doe), .clock_request_out_o(run),
    .system_phase_clock_o(ph), .slow_clock_osc_out_o(sob),
    .fast_clock_osc_out_o(fob), .fast_osc_en_o(fosc),
    .port3_pin_o(p3), .wait_for_interrupt_instr_i(wait_for_interrupt_instr),
    .stop_instr_i(stop_instr), .opcode_fetch_flag_i(fet), .irq_wake_i(wake),
    .cpu_addr_i(cadr), .cpu_wdata_i(cwd), .cpu_we_i(cwe),
    .cpu_ext_i(cext), .int_bus_data_i(idat), .mem_rdata_i(mdat),
    .cpu_ready_o(crdy), .cpu_reset_o(crst), .dma_wr_o(dwr),
    .dma_rd_o(drd),
    .dma_addr_o(dadr), .dma_wdata_o(dwd), .port_out_i(pout),
    .port_dir_i(pdir), .port3_data_i(p3d), .chip_select_n_i(csn),
    .chip_select_enable_i(csen), .nonmaskable_irq_n_o(nmi),
    .level_irq_one_n_o(l1), .level_irq_two_n_o(l2),
    .edge_irq_sel_o(esel)
  );

  bec_far_end i_far (
    .sys_clk_i(clk), .keep_bus_i(keep), .ready_i(rdy), .phase_i(ph),
    .bus_enable_o(be), .slow_clk_o(slow), .fast_clk_o(fast)
  );

  always #2 clk = ~clk;

  // Pulse capture and hang limit
  always @(posedge clk) begin
    cycles++;
    if (dwr) begin
      nwr++;
      cap_a = dadr;
      cap_d = dwd;
    end
    if (drd) nrd++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    wdat <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rdat;
  endtask

  task automatic nx(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Waits for a fresh phase level, not one already under way
  task automatic wph(input logic l);
    for (int j = 0; j < 80 && ph === l; j++) @(negedge clk);
    for (int j = 0; j < 80 && ph !== l; j++) @(negedge clk);
  endtask

  task automatic wrun(input logic l, input int k);
    for (int j = 0; j < k && run !== l; j++) @(negedge clk);
  endtask

  task automatic cnt_ph();
    logic p;
    n = 0;
    p = ph;
    repeat (96) begin
      @(negedge clk);
      if (ph !== p) n++;
      p = ph;
    end
  endtask

  task automatic t_reset();
    rd(8'h1B);
    `CHK("bcfg", bec_pkg::BEC_BUS_CFG_RST, v)
    rd(8'h0A);
    `CHK("tcfg", bec_pkg::BEC_TMR_CFG_RST, v)
    rd(8'h55);
    `CHK("unmapped", 8'h00, v)
    `CHK("fosc", 1'b0, fosc)
    `CHK("weo", 1'b1, weo)
    `CHK("cpu rst", 1'b0, crst)
    $display("reset done");
  endtask

  task automatic t_clk();
    wr(8'h0A, 8'h04);
    nx(4);
    `CHK("fosc", 1'b1, fosc)
    cnt_ph();
    `CHK("slow ph", 1'b1, n < 6)
    wr(8'h0A, 8'h06);
    cnt_ph();
    `CHK("fast ph", 1'b1, n > 10)
    @(posedge slow);
    nx(6);
    `CHK("sob", ~slow, sob)
    @(posedge fast);
    nx(4);
    `CHK("fob", ~fast, fob)
    wr(8'h0A, 8'h00);
    nx(4);
    `CHK("fosc", 1'b0, fosc)
    wr(8'h1B, 8'h72);
    nx(8);
    `CHK("aoe", pdir[15:0], aoe)
    `CHK("ao", pout[15:0], ao)
    `CHK("doe", pdir[23:16], doe)
    `CHK("p3", (csn & csen) | (p3d & ~csen), p3)
    `CHK("esel", 3'h7, esel)
    `CHK("nmi", irqn[0], nmi)
    `CHK("irq1", irqn[1], l1)
    `CHK("irq2", irqn[2], l2)
    wr(8'h1B, 8'h00);
    nx(4);
    `CHK("nmi off", 1'b1, nmi)
    `CHK("irq2 off", 1'b1, l2)
    $display("clock done");
  endtask

  task automatic t_halt();
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge clk);
    wait_for_interrupt_instr <= 1'b0;
    wrun(1'b0, 80);
    `CHK("run wai", 1'b0, run)
    `CHK("halt", 1'b0, crdy)
    nx(40);
    `CHK("run held", 1'b0, run)
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wrun(1'b1, 8);
    `CHK("run irq", 1'b1, run)
    `CHK("ready", 1'b1, crdy)
    @(posedge clk);
    stop_instr <= 1'b1;
    @(posedge clk);
    stop_instr <= 1'b0;
    wrun(1'b0, 80);
    nx(60);
    `CHK("frozen", 1'b1, ph)
    `CHK("run stp", 1'b0, run)
    @(posedge clk);
    rpin <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("cpu rst on", 1'b1, crst)
    rpin <= 1'b1;
    wrun(1'b1, 8);
    `CHK("run rst", 1'b1, run)
    $display("halt done");
  endtask

  task automatic t_emu();
    @(posedge clk);
    keep <= 1'b0;
    rpin <= 1'b0;
    repeat (4) @(posedge clk);
    rpin <= 1'b1;
    repeat (8) @(posedge clk);
    keep <= 1'b1;
    rd(8'h1B);
    `CHK("emu", bec_pkg::BEC_BUS_CFG_EMU, v)
    nx(8);
    `CHK("aoe", 16'hFFFF, aoe)
    `CHK("weoe", 1'b1, weoe)
    wph(1'b0);
    nx(4);
    `CHK("sync", fet, run)
    @(posedge clk);
    cwe <= 1'b1;
    idat <= 8'hC3;
    wph(1'b1);
    nx(4);
    `CHK("run hi", 1'b1, run)
    `CHK("trace", 8'hC3, dout)
    `CHK("trace oe", 8'hFF, doe)
    `CHK("trace a", cadr, ao)
    `CHK("int wr", 1'b1, weo)
    @(posedge clk);
    cext <= 1'b1;
    nx(3);
    `CHK("ext wr", 1'b0, weo)
    `CHK("ext d", cwd, dout)
    `CHK("ext doe", 8'hFF, doe)
    @(posedge clk);
    cwe <= 1'b0;
    cext <= 1'b0;
    $display("emulation done");
  endtask

  task automatic t_dma();
    wph(1'b0);
    @(posedge clk);
    keep <= 1'b0;
    fet <= 1'b1;
    wpin <= 1'b0;
    apin <= 16'h0123;
    dpin <= 8'h5A;
    nx(8);
    `CHK("weoe", 1'b0, weoe)
    `CHK("aoe", 16'h0000, aoe)
    `CHK("halt", 1'b0, crdy)
    `CHK("run", 1'b1, run)
    nx(52);
    `CHK("wr seen", 1'b1, nwr > 0)
    `CHK("wr addr", 16'h0123, cap_a)
    `CHK("wr data", 8'h5A, cap_d)
    @(posedge clk);
    wpin <= 1'b1;
    dpin <= 8'hA5;
    wph(1'b1);
    nx(4);
    `CHK("rd seen", 1'b1, nrd > 0)
    `CHK("rd oe", 8'hFF, doe)
    `CHK("rd data", mdat, dout)
    @(posedge clk);
    keep <= 1'b1;
    nx(8);
    `CHK("bus back", 1'b1, weoe)
    @(posedge clk);
    rdy <= 1'b0;
    wph(1'b1);
    nx(6);
    `CHK("stall", 1'b0, crdy)
    `CHK("aoe kept", 16'hFFFF, aoe)
    `CHK("weoe kept", 1'b1, weoe)
    @(posedge clk);
    rdy <= 1'b1;
    $display("dma done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rpin <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_clk();
    t_halt();
    t_emu();
    t_dma();
    stop_test();
  end
endmodule
